// ==== design/apm_pkg.sv ====
// Constants and types for the auxiliary pin test multiplexer.
// Assumes a single 50 MHz core clock and a byte-wide internal register port.
package apm_pkg;

    // ==========================================================
    // Register offsets (six-bit register address)
    localparam logic [5:0] AUX_SOURCE_SELECT_OFS     = 6'h38;
    localparam logic [5:0] FIRST_TEST_DAC_VALUE_OFS  = 6'h39;
    localparam logic [5:0] SECOND_TEST_DAC_VALUE_OFS = 6'h3A;
    localparam logic [5:0] ADC_IQ_SNAPSHOT_OFS       = 6'h3B;
    localparam logic [5:0] PRODUCTION_RESERVED_A_OFS = 6'h3C;
    localparam logic [5:0] PRODUCTION_RESERVED_B_OFS = 6'h3D;
    localparam logic [5:0] PRODUCTION_RESERVED_C_OFS = 6'h3E;

    // ==========================================================
    // Reset values
    localparam logic [7:0] AUX_SOURCE_SELECT_RST     = 8'h00;
    localparam logic [7:0] PRODUCTION_RESERVED_A_RST = 8'hFF;
    localparam logic [7:0] PRODUCTION_RESERVED_B_RST = 8'h00;
    localparam logic [7:0] PRODUCTION_RESERVED_C_RST = 8'h03;

    // ==========================================================
    // Field positions
    localparam int FIRST_SEL_MSB  = 7;
    localparam int FIRST_SEL_LSB  = 4;
    localparam int SECOND_SEL_MSB = 3;
    localparam int SECOND_SEL_LSB = 0;
    localparam int DAC_VALUE_MSB  = 5;

    // ==========================================================
    // Selector codes
    localparam logic [3:0] SEL_TRISTATE   = 4'h0;
    localparam logic [3:0] SEL_TEST_DAC   = 4'h1;
    localparam logic [3:0] SEL_CORRELATOR = 4'h2;
    localparam logic [3:0] SEL_RSVD_3     = 4'h3;
    localparam logic [3:0] SEL_MIN_LEVEL  = 4'h4;
    localparam logic [3:0] SEL_ADC_I      = 4'h5;
    localparam logic [3:0] SEL_ADC_Q      = 4'h6;
    localparam logic [3:0] SEL_RSVD_7     = 4'h7;
    localparam logic [3:0] SEL_PRODUCTION = 4'h8;
    localparam logic [3:0] SEL_RSVD_9     = 4'h9;
    localparam logic [3:0] SEL_HIGH       = 4'hA;
    localparam logic [3:0] SEL_LOW        = 4'hB;
    localparam logic [3:0] SEL_TX_ACTIVE  = 4'hC;
    localparam logic [3:0] SEL_RX_ACTIVE  = 4'hD;
    localparam logic [3:0] SEL_SUBCARRIER = 4'hE;
    localparam logic [3:0] SEL_PROBE_BIT  = 4'hF;

    // ==========================================================
    // Carrier for one observation pin
    typedef struct packed {
        logic drive;
        logic level;
    } apm_pin_type;

endpackage : apm_pkg

// ==== design/apm_aux_pin_test_mux.sv ====
// Auxiliary pin test multiplexer with test DAC, ADC snapshot and reserved registers.
// Assumes the serial front end presents decoded single-cycle register accesses
// and that activity and probe signals come from logic on ref_clk.
//
// Overview of operation
// - Select register 38h, two nibble selectors, reset 00h
// - 0000 tristate, 1010 high, 1011 low
// - 0001 routes test DAC to its pin
// - 0010/0100/0101/0110 route analog test signals
// - 1100 shows transmit activity
// - 1101 shows receive activity
// - 1110 subcarrier detect, none at 106 kbit/s
// - 1111 outputs chosen test-bus bit
// - 39h holds first DAC value, all eight bits kept, low six drive DAC
// - 3Ah holds six-bit second DAC value
// - 3Bh reads ADC I and Q nibbles
// - 3Ch-3Eh reserved, reset FFh 00h 03h
`timescale 1ns/10ps

module apm_aux_pin_test_mux (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    // Register port from the serial front end
    input  wire logic [5:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    // Core observation sources
    input  wire logic       transmit_activity,
    input  wire logic       receive_activity,
    input  wire logic       subcarrier_detected,
    input  wire logic       rate_is_106k,
    input  wire logic [7:0] probe_bus,
    input  wire logic [2:0] probe_bit_pick,
    // Analog side
    input  wire logic [3:0] adc_i_value,
    input  wire logic [3:0] adc_q_value,
    output logic      [3:0] first_analog_sel,
    output logic      [3:0] second_analog_sel,
    output logic      [5:0] first_dac_value,
    output logic      [5:0] second_dac_value,
    // Observation pins
    output logic            first_observe_pin_out,
    output logic            first_observe_pin_oe,
    output logic            second_observe_pin_out,
    output logic            second_observe_pin_oe
);

    // ==========================================================
    // Decoding shared by both pins
    function automatic logic is_analog(input logic [3:0] code);
        is_analog = (code == apm_pkg::SEL_TEST_DAC) || (code == apm_pkg::SEL_CORRELATOR) ||
                    (code == apm_pkg::SEL_MIN_LEVEL) || (code == apm_pkg::SEL_ADC_I) ||
                    (code == apm_pkg::SEL_ADC_Q) || (code == apm_pkg::SEL_PRODUCTION);
    endfunction : is_analog

    function automatic apm_pkg::apm_pin_type pin_mux(input logic [3:0] code,
                                                      input logic       tx,
                                                      input logic       rx,
                                                      input logic       sub,
                                                      input logic       rate106,
                                                      input logic       probe);
        pin_mux = '{drive: 1'b1, level: 1'b0};
        case (code)
            apm_pkg::SEL_HIGH:       pin_mux.level = 1'b1;
            apm_pkg::SEL_LOW:        pin_mux.level = 1'b0;
            apm_pkg::SEL_TX_ACTIVE:  pin_mux.level = tx;
            apm_pkg::SEL_RX_ACTIVE:  pin_mux.level = rx;
            apm_pkg::SEL_SUBCARRIER: pin_mux.level = sub & ~rate106;
            apm_pkg::SEL_PROBE_BIT:  pin_mux.level = probe;
            // Tristate, reserved and analog codes release the pin
            default:                 pin_mux.drive = 1'b0;
        endcase
    endfunction : pin_mux

    // ==========================================================
    // Control registers with reset
    logic [7:0] select_reg, select_next;
    logic [7:0] rsvd_a_reg, rsvd_a_next;
    logic [7:0] rsvd_b_reg, rsvd_b_next;
    logic [7:0] rsvd_c_reg, rsvd_c_next;

    always_comb begin
        select_next = select_reg;
        rsvd_a_next = rsvd_a_reg;
        rsvd_b_next = rsvd_b_reg;
        rsvd_c_next = rsvd_c_reg;
        if (reg_wr) begin
            case (reg_addr)
                apm_pkg::AUX_SOURCE_SELECT_OFS:     select_next = reg_wdata;
                apm_pkg::PRODUCTION_RESERVED_A_OFS: rsvd_a_next = reg_wdata;
                apm_pkg::PRODUCTION_RESERVED_B_OFS: rsvd_b_next = reg_wdata;
                apm_pkg::PRODUCTION_RESERVED_C_OFS: rsvd_c_next = reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            select_reg <= apm_pkg::AUX_SOURCE_SELECT_RST;
            rsvd_a_reg <= apm_pkg::PRODUCTION_RESERVED_A_RST;
            rsvd_b_reg <= apm_pkg::PRODUCTION_RESERVED_B_RST;
            rsvd_c_reg <= apm_pkg::PRODUCTION_RESERVED_C_RST;
        end else begin
            select_reg <= select_next;
            rsvd_a_reg <= rsvd_a_next;
            rsvd_b_reg <= rsvd_b_next;
            rsvd_c_reg <= rsvd_c_next;
        end
    end

    // ==========================================================
    // Unreset storage: DAC values and ADC snapshot
    // Saves reset flops; contents are unknown until written or sampled.
    logic [7:0] dac1_reg, dac1_next;
    logic [7:0] dac2_reg, dac2_next;
    logic [3:0] adc_i_meta, adc_q_meta;
    logic [7:0] snapshot_reg, snapshot_next;

    always_comb begin
        dac1_next     = dac1_reg;
        dac2_next     = dac2_reg;
        snapshot_next = {adc_i_meta, adc_q_meta};
        if (reg_wr && reg_addr == apm_pkg::FIRST_TEST_DAC_VALUE_OFS) begin
            dac1_next = reg_wdata;
        end
        if (reg_wr && reg_addr == apm_pkg::SECOND_TEST_DAC_VALUE_OFS) begin
            dac2_next = {2'b00, reg_wdata[apm_pkg::DAC_VALUE_MSB:0]};
        end
    end

    // ADC comes from the analog domain; second stage is the snapshot itself
    always_ff @(posedge ref_clk) begin
        dac1_reg     <= dac1_next;
        dac2_reg     <= dac2_next;
        adc_i_meta   <= adc_i_value;
        adc_q_meta   <= adc_q_value;
        snapshot_reg <= snapshot_next;
    end

    // ==========================================================
    // Read path
    logic [7:0] rdata_next;
    logic       rvalid_next;

    always_comb begin
        rvalid_next = reg_rd;
        rdata_next  = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                apm_pkg::AUX_SOURCE_SELECT_OFS:     rdata_next = select_reg;
                apm_pkg::FIRST_TEST_DAC_VALUE_OFS:  rdata_next = dac1_reg;
                apm_pkg::SECOND_TEST_DAC_VALUE_OFS: rdata_next = dac2_reg;
                apm_pkg::ADC_IQ_SNAPSHOT_OFS:       rdata_next = snapshot_reg;
                apm_pkg::PRODUCTION_RESERVED_A_OFS: rdata_next = rsvd_a_reg;
                apm_pkg::PRODUCTION_RESERVED_B_OFS: rdata_next = rsvd_b_reg;
                apm_pkg::PRODUCTION_RESERVED_C_OFS: rdata_next = rsvd_c_reg;
                default:                            rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= rdata_next;
            reg_rvalid <= rvalid_next;
        end
    end

    // ==========================================================
    // Pin and analog select drive
    logic [3:0]           sel1, sel2;
    logic                 probe_bit;
    apm_pkg::apm_pin_type pin1_next, pin2_next;
    logic [3:0]           asel1_next, asel2_next;

    assign sel1      = select_reg[apm_pkg::FIRST_SEL_MSB:apm_pkg::FIRST_SEL_LSB];
    assign sel2      = select_reg[apm_pkg::SECOND_SEL_MSB:apm_pkg::SECOND_SEL_LSB];
    assign probe_bit = probe_bus[probe_bit_pick];

    always_comb begin
        pin1_next  = pin_mux(sel1, transmit_activity, receive_activity,
                             subcarrier_detected, rate_is_106k, probe_bit);
        pin2_next  = pin_mux(sel2, transmit_activity, receive_activity,
                             subcarrier_detected, rate_is_106k, probe_bit);
        asel1_next = is_analog(sel1) ? sel1 : apm_pkg::SEL_TRISTATE;
        asel2_next = is_analog(sel2) ? sel2 : apm_pkg::SEL_TRISTATE;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            first_observe_pin_out  <= 1'b0;
            first_observe_pin_oe   <= 1'b0;
            second_observe_pin_out <= 1'b0;
            second_observe_pin_oe  <= 1'b0;
            first_analog_sel       <= apm_pkg::SEL_TRISTATE;
            second_analog_sel      <= apm_pkg::SEL_TRISTATE;
            first_dac_value        <= 6'h00;
            second_dac_value       <= 6'h00;
        end else begin
            first_observe_pin_out  <= pin1_next.level;
            first_observe_pin_oe   <= pin1_next.drive;
            second_observe_pin_out <= pin2_next.level;
            second_observe_pin_oe  <= pin2_next.drive;
            first_analog_sel       <= asel1_next;
            second_analog_sel      <= asel2_next;
            first_dac_value        <= dac1_reg[apm_pkg::DAC_VALUE_MSB:0];
            second_dac_value       <= dac2_reg[apm_pkg::DAC_VALUE_MSB:0];
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence seq_write(logic [5:0] ofs);
        reg_wr && reg_addr == ofs;
    endsequence

    sequence seq_read(logic [5:0] ofs);
        reg_rd && !reg_wr && reg_addr == ofs;
    endsequence

    AST_SEL_WRITE_READ: assert property (seq_write(apm_pkg::AUX_SOURCE_SELECT_OFS) ##1
        seq_read(apm_pkg::AUX_SOURCE_SELECT_OFS) |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2))
        else $error("Select register readback mismatch");
    AST_TRISTATE: assert property (sel1 == apm_pkg::SEL_TRISTATE |=> !first_observe_pin_oe)
        else $error("First pin driven while tristate selected");
    AST_HIGH_LOW: assert property (sel2 == apm_pkg::SEL_HIGH ##1 sel2 == apm_pkg::SEL_LOW
        |-> second_observe_pin_oe && second_observe_pin_out ##1 !second_observe_pin_out)
        else $error("Second pin constant level wrong");
    AST_ANALOG_SEL: assert property (sel1 == apm_pkg::SEL_ADC_I |=>
        first_analog_sel == apm_pkg::SEL_ADC_I && !first_observe_pin_oe)
        else $error("Analog code not passed to analog side");
    AST_TX: assert property (sel1 == apm_pkg::SEL_TX_ACTIVE |=>
        first_observe_pin_out == $past(transmit_activity))
        else $error("Transmit activity not shown");
    AST_RX: assert property (sel2 == apm_pkg::SEL_RX_ACTIVE |=>
        second_observe_pin_out == $past(receive_activity) && second_observe_pin_oe)
        else $error("Receive activity not shown");
    AST_SUBC_106: assert property (sel1 == apm_pkg::SEL_SUBCARRIER && rate_is_106k |=>
        !first_observe_pin_out)
        else $error("Subcarrier shown at 106 kbit/s");
    AST_PROBE: assert property (sel2 == apm_pkg::SEL_PROBE_BIT |=>
        second_observe_pin_out == $past(probe_bit))
        else $error("Probe bit not routed");
    AST_DAC1: assert property (seq_write(apm_pkg::FIRST_TEST_DAC_VALUE_OFS) |=>
        ##1 {2'b00, first_dac_value} == ($past(reg_wdata, 2) & 8'h3F))
        else $error("First DAC value not applied");
    AST_DAC2_RSVD: assert property (seq_write(apm_pkg::SECOND_TEST_DAC_VALUE_OFS) ##1
        seq_read(apm_pkg::SECOND_TEST_DAC_VALUE_OFS) |=> reg_rdata[7:6] == 2'b00)
        else $error("Second DAC reserved bits not zero");
    AST_ADC: assert property (seq_read(apm_pkg::ADC_IQ_SNAPSHOT_OFS) |=>
        reg_rdata == {$past(adc_i_value, 3), $past(adc_q_value, 3)})
        else $error("ADC snapshot readback wrong");
    AST_RSVD_RST: assert property ($rose(resetn) |-> rsvd_a_reg == 8'hFF && rsvd_c_reg == 8'h03)
        else $error("Reserved register reset value wrong");

endmodule : apm_aux_pin_test_mux

// ==== verif/apm_pin_observer.sv ====
// Test equipment model that watches the two observation pins.
// Assumes each pin has an external pull-down that wins while the device releases it.
`timescale 1ns/10ps

module apm_pin_observer (
    // Pin drivers from the device
    input  wire logic first_pin_out,
    input  wire logic first_pin_oe,
    input  wire logic second_pin_out,
    input  wire logic second_pin_oe,
    // Levels seen at the probe tips
    output logic      first_pin_level,
    output logic      second_pin_level
);
    // ==========================================================
    // Wire resolution
    // Released pin sinks to the pull-down, so a stale level cannot pass
    assign first_pin_level  = first_pin_oe ? first_pin_out : 1'b0;
    assign second_pin_level = second_pin_oe ? second_pin_out : 1'b0;
endmodule : apm_pin_observer

// ==== verif/test_aux_pin_test_mux.sv ====
// Self-checking bench for the auxiliary pin test multiplexer.
// Assumes the decoded register port with strobes held until the next access and the pin observer model.
`timescale 1ns/10ps

module test_aux_pin_test_mux;
    logic       ref_clk = 1'b0;
    logic       resetn = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    logic       tx = 1'b0;
    logic       rx = 1'b0;
    logic       sub = 1'b0;
    logic       r106 = 1'b0;
    logic [7:0] pbus = 8'h00;
    logic [2:0] pick = 3'h0;
    logic [3:0] adc_i = 4'h0;
    logic [3:0] adc_q = 4'h0;
    logic [3:0] sel1, sel2;
    logic [5:0] dac1, dac2;
    logic       out1, oe1, out2, oe2, lvl1, lvl2;
    int         err_count = 0;
    int         n_compared = 0;
    int         cycles = 0;
    logic       want;

    always #10 ref_clk = ~ref_clk;

    apm_aux_pin_test_mux DUT (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .transmit_activity(tx), .receive_activity(rx),
        .subcarrier_detected(sub), .rate_is_106k(r106), .probe_bus(pbus),
        .probe_bit_pick(pick), .adc_i_value(adc_i), .adc_q_value(adc_q),
        .first_analog_sel(sel1), .second_analog_sel(sel2), .first_dac_value(dac1),
        .second_dac_value(dac2), .first_observe_pin_out(out1), .first_observe_pin_oe(oe1),
        .second_observe_pin_out(out2), .second_observe_pin_oe(oe2));

    apm_pin_observer probe (.first_pin_out(out1), .first_pin_oe(oe1),
        .second_pin_out(out2), .second_pin_oe(oe2),
        .first_pin_level(lvl1), .second_pin_level(lvl2));

    // ==========================================================
    // Checking and closing
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        $display("compares %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    // Hang guard, far above the roughly 160 cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            complete_run();
        end
    end

    // ==========================================================
    // Register port tasks, driven on the falling edge
    // Strobe stays up until the next call: a repeated access is harmless,
    // and back-to-back calls never pulse one strobe twice in a time step
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        reg_rd = 1'b0;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        reg_wr = 1'b0;
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        check("read valid", {7'h00, reg_rvalid}, 8'h01);
        check("read data", reg_rdata, exp);
    endtask : rd

    task automatic do_reset;
        resetn = 1'b0;
        repeat (4) @(negedge ref_clk);
        resetn = 1'b1;
        @(negedge ref_clk);
    endtask : do_reset

    // ==========================================================
    // Main sequence
    initial begin
        do_reset();
        rd(apm_pkg::AUX_SOURCE_SELECT_OFS, 8'h00);
        rd(apm_pkg::PRODUCTION_RESERVED_A_OFS, 8'hFF);
        rd(apm_pkg::PRODUCTION_RESERVED_B_OFS, 8'h00);
        rd(apm_pkg::PRODUCTION_RESERVED_C_OFS, 8'h03);
        check("pin enables", {6'h00, oe1, oe2}, 8'h00);
        wr(apm_pkg::FIRST_TEST_DAC_VALUE_OFS, 8'hE5);
        wr(apm_pkg::SECOND_TEST_DAC_VALUE_OFS, 8'hFF);
        rd(apm_pkg::SECOND_TEST_DAC_VALUE_OFS, 8'h3F);
        rd(apm_pkg::FIRST_TEST_DAC_VALUE_OFS, 8'hE5);
        check("first dac", {2'h0, dac1}, 8'h25);
        check("second dac", {2'h0, dac2}, 8'h3F);
        adc_i = 4'hA;
        adc_q = 4'h5;
        wr(apm_pkg::ADC_IQ_SNAPSHOT_OFS, 8'h00);
        wr(6'h3F, 8'hFF);
        repeat (3) @(negedge ref_clk);
        rd(apm_pkg::ADC_IQ_SNAPSHOT_OFS, 8'hA5);
        rd(6'h3F, 8'h00);
        // Two source sets so every routed code must change level between the sets
        for (int s = 0; s < 2; s++) begin
            tx = (s == 0);
            rx = (s == 1);
            sub = 1'b1;
            r106 = (s == 1);
            pbus = (s == 0) ? 8'h08 : 8'hF7;
            pick = 3'h3;
            for (int c = 0; c < 16; c++) begin
                wr(apm_pkg::AUX_SOURCE_SELECT_OFS, {c[3:0], c[3:0]});
                repeat (2) @(negedge ref_clk);
                case (c[3:0])
                    apm_pkg::SEL_HIGH: want = 1'b1;
                    apm_pkg::SEL_TX_ACTIVE: want = tx;
                    apm_pkg::SEL_RX_ACTIVE: want = rx;
                    apm_pkg::SEL_SUBCARRIER: want = sub & ~r106;
                    apm_pkg::SEL_PROBE_BIT: want = pbus[pick];
                    default: want = 1'b0;
                endcase
                check("pin enables", {6'h00, oe1, oe2}, (c >= 10) ? 8'h03 : 8'h00);
                check("pin levels", {6'h00, lvl1, lvl2}, {6'h00, want, want});
                check("analog select", {sel1, sel2},
                      (c inside {1, 2, 4, 5, 6, 8}) ? {c[3:0], c[3:0]} : 8'h00);
                rd(apm_pkg::AUX_SOURCE_SELECT_OFS, {c[3:0], c[3:0]});
            end
        end
        wr(apm_pkg::AUX_SOURCE_SELECT_OFS, 8'hAB);
        rd(apm_pkg::AUX_SOURCE_SELECT_OFS, 8'hAB);
        do_reset();
        rd(apm_pkg::AUX_SOURCE_SELECT_OFS, 8'h00);
        check("pin enables", {6'h00, oe1, oe2}, 8'h00);
        complete_run();
    end
endmodule : test_aux_pin_test_mux
